// file: rtl/core_sfr_bank.sv
// core special function register bank with indirect data memory ports
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// How it works
// - shared addresses resolved by peripheral mode
// - slave address and mask stored separately
// - serial mode selects address or mask
// - parallel address/output pair is one store
// - pair is written and read the same in parallel master and slave mode
// - table pointer high/low bytes hold bits 15:0
// - offset port uses pointer plus working reg
// - several names decode to one address
// - plain port uses pointer, leaves it unchanged
module core_sfr_bank (
  input  wire logic        clk_sys,     // 10 mhz core clock
  input  wire logic        rst,         // synchronous, active high
  input  wire logic        hsel,        // ahb slave select
  input  wire logic [31:0] haddr,       // byte address
  input  wire logic [1:0]  htrans,      // transfer type
  input  wire logic        hwrite,      // write when high
  input  wire logic [2:0]  hsize,       // word only
  input  wire logic        hready,      // bus ready in
  input  wire logic [31:0] hwdata,      // write data
  output logic      [31:0] hrdata,      // read data
  output logic             hreadyout,   // slave ready
  output logic             hresp,       // always okay
  output logic      [11:0] indirect_pointer_zero,        // pointer 0 value
  output logic      [20:0] tablePtr,    // program table pointer
  output logic             serMaskSel,  // serial mask selected
  output logic             parMaster    // parallel port master mode
);

  //////////////////////////////////////////////////////////////////////////////
  // address phase capture
  logic        pendWr_ff;     // write data phase pending
  logic        pendRd_ff;     // read data phase pending
  logic [11:0] pendIdx_ff;    // register index of the pending access
  logic        acc;           // valid address phase this cycle
  logic [11:0] aIdx;          // index taken from byte address

  assign acc  = hsel && hready && (htrans == core_sfr_pkg::HTRANS_NSEQ);
  assign aIdx = haddr[13:2];

  // one cycle address phase, every data phase answers with no wait
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pendWr_ff  <= 1'b0;
      pendRd_ff  <= 1'b0;
      pendIdx_ff <= 12'h000;
    end else begin
      pendWr_ff  <= acc && hwrite;
      pendRd_ff  <= acc && !hwrite;
      pendIdx_ff <= acc ? aIdx : pendIdx_ff;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  //////////////////////////////////////////////////////////////////////////////
  // stored registers
  logic [7:0] working_register_ff, fsrL_ff, fsrH_ff;
  logic [7:0] ictl1_ff, ictl2_ff, ictl3_ff, product_low_ff, product_high_ff;
  logic [7:0] table_latch_ff, tblL_ff, tblH_ff, tblU_ff;
  logic [7:0] pcl_ff, program_counter_hold_high_ff, program_counter_hold_upper_ff, stk_ff;
  logic [7:0] stack_top_low_ff, stack_top_high_ff, stack_top_upper_ff;
  logic [7:0] serAddr_ff;     // serial slave address store
  logic [7:0] serMask_ff;     // serial address mask store
  logic [7:0] parH_ff;        // one parallel pair, high byte
  logic [7:0] parL_ff;        // one parallel pair, low byte
  logic [7:0] mode_ff;        // mode control byte
  logic [7:0] dmem [core_sfr_pkg::DMEM_DEPTH]; // indirect target memory

  logic [7:0] wb;             // write byte from low lane
  logic       wr;             // write data phase this cycle
  assign wb = hwdata[7:0];
  assign wr = pendWr_ff;

  // wr to a given index, as a helper function
  function automatic logic hit(input logic [11:0] idx);
    hit = wr && (pendIdx_ff == idx);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // indirect address generation for pointer 0
  logic       isInd;          // pending index is an indirect port
  logic [11:0] indAddr;       // data memory address of the access
  logic [11:0] fsrNow;        // current pointer value

  assign fsrNow = {fsrH_ff[3:0], fsrL_ff};
  assign indirect_pointer_zero   = fsrNow;

  always_comb begin
    isInd   = 1'b1;
    indAddr = fsrNow;
    case (pendIdx_ff)
      core_sfr_pkg::IDX_INDIRECT_PLAIN_PORT_0,
      core_sfr_pkg::IDX_POSTINC,
      core_sfr_pkg::IDX_POSTDEC: indAddr = fsrNow;
      core_sfr_pkg::IDX_PREINC:  indAddr = fsrNow + 12'h001;
      // offset is the working register taken as signed
      core_sfr_pkg::IDX_PLUSW:
        indAddr = fsrNow + {{4{working_register_ff[7]}}, working_register_ff};
      default: isInd = 1'b0;
    endcase
  end

  // data memory behind the ports; ports themselves hold no storage
  always_ff @(posedge clk_sys) begin
    if (wr && isInd) begin
      dmem[indAddr] <= wb;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pointer 0 update: direct writes, then port side effects
  logic [11:0] nxt_fsr;
  always_comb begin
    nxt_fsr = fsrNow;
    if (hit(core_sfr_pkg::IDX_INDIRECT_POINTER0_LOW)) nxt_fsr[7:0]  = wb;
    if (hit(core_sfr_pkg::IDX_INDIRECT_POINTER0_HIGH)) nxt_fsr[11:8] = wb[3:0];
    if (pendWr_ff || pendRd_ff) begin
      case (pendIdx_ff)
        core_sfr_pkg::IDX_POSTINC,
        core_sfr_pkg::IDX_PREINC:  nxt_fsr = fsrNow + 12'h001;
        core_sfr_pkg::IDX_POSTDEC: nxt_fsr = fsrNow - 12'h001;
        default: ;                 // plain and offset leave it
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fsrL_ff <= core_sfr_pkg::RST_ZERO;
      fsrH_ff <= core_sfr_pkg::RST_ZERO;
    end else begin
      fsrL_ff <= nxt_fsr[7:0];
      fsrH_ff <= {4'h0, nxt_fsr[11:8]};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // plain core registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      working_register_ff   <= core_sfr_pkg::RST_ZERO;
      ictl1_ff  <= core_sfr_pkg::RST_ZERO;
      ictl2_ff  <= core_sfr_pkg::RST_ICTL2;
      ictl3_ff  <= core_sfr_pkg::RST_ICTL3;
      product_low_ff  <= core_sfr_pkg::RST_ZERO;
      product_high_ff  <= core_sfr_pkg::RST_ZERO;
      table_latch_ff <= core_sfr_pkg::RST_ZERO;
      pcl_ff    <= core_sfr_pkg::RST_ZERO;
      program_counter_hold_high_ff <= core_sfr_pkg::RST_ZERO;
      program_counter_hold_upper_ff <= core_sfr_pkg::RST_ZERO;
      stk_ff    <= core_sfr_pkg::RST_ZERO;
      stack_top_low_ff   <= core_sfr_pkg::RST_ZERO;
      stack_top_high_ff   <= core_sfr_pkg::RST_ZERO;
      stack_top_upper_ff   <= core_sfr_pkg::RST_ZERO;
    end else begin
      if (hit(core_sfr_pkg::IDX_WORKING_REGISTER))   working_register_ff   <= wb;
      if (hit(core_sfr_pkg::IDX_ICTL1))  ictl1_ff  <= wb;
      if (hit(core_sfr_pkg::IDX_ICTL2))  ictl2_ff  <= wb;
      if (hit(core_sfr_pkg::IDX_ICTL3))  ictl3_ff  <= wb;
      if (hit(core_sfr_pkg::IDX_PRODUCT_LOW))  product_low_ff  <= wb;
      if (hit(core_sfr_pkg::IDX_PRODUCT_HIGH))  product_high_ff  <= wb;
      if (hit(core_sfr_pkg::IDX_TABLE_LATCH)) table_latch_ff <= wb;
      if (hit(core_sfr_pkg::IDX_PCL))    pcl_ff    <= wb;
      if (hit(core_sfr_pkg::IDX_PROGRAM_COUNTER_HOLD_HIGH)) program_counter_hold_high_ff <= wb;
      // unimplemented upper bits stay zero
      if (hit(core_sfr_pkg::IDX_PROGRAM_COUNTER_HOLD_UPPER))
        program_counter_hold_upper_ff <= wb & core_sfr_pkg::MSK_U5;
      if (hit(core_sfr_pkg::IDX_STACK_POINTER_STATUS))
        stk_ff <= wb & core_sfr_pkg::MSK_STK;
      if (hit(core_sfr_pkg::IDX_STACK_TOP_LOW))   stack_top_low_ff   <= wb;
      if (hit(core_sfr_pkg::IDX_STACK_TOP_HIGH))   stack_top_high_ff   <= wb;
      if (hit(core_sfr_pkg::IDX_STACK_TOP_UPPER))
        stack_top_upper_ff <= wb & core_sfr_pkg::MSK_U5;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // table pointer, byte addressable
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tblL_ff <= core_sfr_pkg::RST_ZERO;
      tblH_ff <= core_sfr_pkg::RST_ZERO;
      tblU_ff <= core_sfr_pkg::RST_ZERO;
    end else begin
      if (hit(core_sfr_pkg::IDX_TBLL)) tblL_ff <= wb;
      if (hit(core_sfr_pkg::IDX_TBLH)) tblH_ff <= wb;
      if (hit(core_sfr_pkg::IDX_TBLU))
        tblU_ff <= wb & core_sfr_pkg::MSK_TBLU;
    end
  end
  assign tablePtr = {tblU_ff[4:0], tblH_ff, tblL_ff};

  //////////////////////////////////////////////////////////////////////////////
  // mode control and context-defined stores
  assign serMaskSel = mode_ff[core_sfr_pkg::MODE_MASKSEL];
  assign parMaster  = mode_ff[core_sfr_pkg::MODE_PARMST];

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mode_ff <= core_sfr_pkg::RST_ZERO;
    end else if (hit(core_sfr_pkg::IDX_MODECTL)) begin
      mode_ff <= wb & 8'h03;
    end
  end

  // two stores behind one address; the serial mode picks the target
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      serAddr_ff <= core_sfr_pkg::RST_ZERO;
      serMask_ff <= core_sfr_pkg::RST_FF;
    end else if (hit(core_sfr_pkg::IDX_SERSHARE)) begin
      if (serMaskSel) serMask_ff <= wb;
      else            serAddr_ff <= wb;
    end
  end

  // one physical pair under two names; no duplicate copy to drift
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      parH_ff <= core_sfr_pkg::RST_ZERO;
      parL_ff <= core_sfr_pkg::RST_ZERO;
    end else begin
      if (hit(core_sfr_pkg::IDX_PARADRH) ||
          hit(core_sfr_pkg::IDX_PAROUTH)) parH_ff <= wb;
      if (hit(core_sfr_pkg::IDX_PARADRL) ||
          hit(core_sfr_pkg::IDX_PAROUTL)) parL_ff <= wb;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read data multiplexer, registered for the data phase
  logic [7:0] rdByte;
  always_comb begin
    case (aIdx)
      core_sfr_pkg::IDX_WORKING_REGISTER:    rdByte = working_register_ff;
      core_sfr_pkg::IDX_INDIRECT_POINTER0_LOW:   rdByte = fsrL_ff;
      core_sfr_pkg::IDX_INDIRECT_POINTER0_HIGH:   rdByte = fsrH_ff & core_sfr_pkg::MSK_HI4;
      core_sfr_pkg::IDX_INDIRECT_PLAIN_PORT_0,
      core_sfr_pkg::IDX_POSTINC,
      core_sfr_pkg::IDX_POSTDEC: rdByte = dmem[fsrNow];
      core_sfr_pkg::IDX_PREINC:  rdByte = dmem[fsrNow + 12'h001];
      core_sfr_pkg::IDX_PLUSW:
        rdByte = dmem[fsrNow + {{4{working_register_ff[7]}}, working_register_ff}];
      core_sfr_pkg::IDX_ICTL1:   rdByte = ictl1_ff;
      core_sfr_pkg::IDX_ICTL2:   rdByte = ictl2_ff;
      core_sfr_pkg::IDX_ICTL3:   rdByte = ictl3_ff;
      core_sfr_pkg::IDX_PRODUCT_LOW:   rdByte = product_low_ff;
      core_sfr_pkg::IDX_PRODUCT_HIGH:   rdByte = product_high_ff;
      core_sfr_pkg::IDX_TABLE_LATCH:  rdByte = table_latch_ff;
      core_sfr_pkg::IDX_TBLL:    rdByte = tblL_ff;
      core_sfr_pkg::IDX_TBLH:    rdByte = tblH_ff;
      core_sfr_pkg::IDX_TBLU:    rdByte = tblU_ff;
      core_sfr_pkg::IDX_PCL:     rdByte = pcl_ff;
      core_sfr_pkg::IDX_PROGRAM_COUNTER_HOLD_HIGH:  rdByte = program_counter_hold_high_ff;
      core_sfr_pkg::IDX_PROGRAM_COUNTER_HOLD_UPPER:  rdByte = program_counter_hold_upper_ff;
      core_sfr_pkg::IDX_STACK_POINTER_STATUS:  rdByte = stk_ff;
      core_sfr_pkg::IDX_STACK_TOP_LOW:    rdByte = stack_top_low_ff;
      core_sfr_pkg::IDX_STACK_TOP_HIGH:    rdByte = stack_top_high_ff;
      core_sfr_pkg::IDX_STACK_TOP_UPPER:    rdByte = stack_top_upper_ff;
      core_sfr_pkg::IDX_SERSHARE:
        rdByte = serMaskSel ? serMask_ff : serAddr_ff;
      core_sfr_pkg::IDX_PARADRH,
      core_sfr_pkg::IDX_PAROUTH: rdByte = parH_ff;
      core_sfr_pkg::IDX_PARADRL,
      core_sfr_pkg::IDX_PAROUTL: rdByte = parL_ff;
      core_sfr_pkg::IDX_MODECTL: rdByte = mode_ff;
      default:                   rdByte = 8'h00; // unmapped reads zero
    endcase
  end

  // read is sampled at the address phase; the pointer cannot move between
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (acc && !hwrite) begin
      hrdata <= {24'h000000, rdByte};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  // every check runs on the core clock and sleeps through reset
  default clocking coreCk @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // post-increment port steps the pointer up once per access
  chk_postinc_step: assert property (
    (pendWr_ff || pendRd_ff) && pendIdx_ff == core_sfr_pkg::IDX_POSTINC
    |=> indirect_pointer_zero == $past(indirect_pointer_zero) + 12'h001)
    else $error("pointer did not step up after post-increment access");

  // post-decrement port steps the pointer down once per access
  chk_postdec_step: assert property (
    (pendWr_ff || pendRd_ff) && pendIdx_ff == core_sfr_pkg::IDX_POSTDEC
    |=> indirect_pointer_zero == $past(indirect_pointer_zero) - 12'h001)
    else $error("pointer did not step down after post-decrement access");

  // pre-increment port leaves the pointer on the byte it reached
  chk_preinc_step: assert property (
    (pendWr_ff || pendRd_ff) && pendIdx_ff == core_sfr_pkg::IDX_PREINC
    |=> indirect_pointer_zero == $past(indirect_pointer_zero) + 12'h001)
    else $error("pointer did not step up after pre-increment access");

  // plain and offset ports hold no state and never move the pointer
  chk_plain_hold: assert property (
    (pendWr_ff || pendRd_ff) && (pendIdx_ff == core_sfr_pkg::IDX_INDIRECT_PLAIN_PORT_0 ||
                                 pendIdx_ff == core_sfr_pkg::IDX_PLUSW)
    |=> $stable(indirect_pointer_zero))
    else $error("pointer changed on plain or offset access");

  // an offset write lands at pointer plus signed working register; the
  // place is worked out from sampled values, not from the address path
  chk_offset_addr: assert property (
    pendWr_ff && pendIdx_ff == core_sfr_pkg::IDX_PLUSW
    |=> dmem[$past(indirect_pointer_zero) + {{4{$past(working_register_ff[7])}}, $past(working_register_ff)}]
        == $past(wb))
    else $error("offset port write landed at the wrong byte");

  // an offset read returns the byte at pointer plus signed working reg
  chk_offset_read: assert property (
    acc && !hwrite && aIdx == core_sfr_pkg::IDX_PLUSW
    |=> hrdata[7:0] ==
        $past(dmem[indirect_pointer_zero + {{4{working_register_ff[7]}}, working_register_ff}]))
    else $error("offset port read the wrong byte");

  // high byte of the table pointer lands on bits 15:8
  chk_tbl_bytes: assert property (
    hit(core_sfr_pkg::IDX_TBLH) |=> tablePtr[15:8] == $past(wb))
    else $error("table pointer high byte not written");

  // in mask mode the shared slot writes the mask and spares the address
  chk_ser_route: assert property (
    hit(core_sfr_pkg::IDX_SERSHARE) && serMaskSel
    |=> serMask_ff == $past(wb) && $stable(serAddr_ff))
    else $error("mask write reached slave address store");

  // in address mode the shared slot writes the address and spares the mask
  chk_ser_addr: assert property (
    hit(core_sfr_pkg::IDX_SERSHARE) && !serMaskSel
    |=> serAddr_ff == $past(wb) && $stable(serMask_ff))
    else $error("slave address write misrouted");

  // the second name of the pair writes the same low byte
  chk_par_alias: assert property (
    hit(core_sfr_pkg::IDX_PAROUTL) |=> parL_ff == $past(wb))
    else $error("second name of parallel pair does not alias");

  // the first name of the pair writes the one high byte store
  chk_par_high: assert property (
    hit(core_sfr_pkg::IDX_PARADRH) |=> parH_ff == $past(wb))
    else $error("parallel pair high byte not written");

  // both names of the low byte read the one store, upper lanes zero
  chk_par_read: assert property (
    acc && !hwrite && (aIdx == core_sfr_pkg::IDX_PARADRL ||
                       aIdx == core_sfr_pkg::IDX_PAROUTL)
    |=> hrdata == {24'h000000, $past(parL_ff)})
    else $error("names of the parallel pair read different bytes");

  // main scenarios the sequence should reach
  cov_postinc: cover property (
    pendWr_ff && pendIdx_ff == core_sfr_pkg::IDX_POSTINC);
  cov_preinc: cover property (
    pendRd_ff && pendIdx_ff == core_sfr_pkg::IDX_PREINC);
  cov_plusw: cover property (
    pendRd_ff && pendIdx_ff == core_sfr_pkg::IDX_PLUSW);
  cov_mask: cover property (
    hit(core_sfr_pkg::IDX_SERSHARE) && serMaskSel);
  cov_paralias: cover property (
    hit(core_sfr_pkg::IDX_PARADRH) && parMaster);

endmodule // core_sfr_bank

// file: rtl/core_sfr_pkg.sv
// package of offsets, field layouts and reset values for the core sfr bank
package core_sfr_pkg;
  // sfr offsets are not word multiples: each is an index, byte = 4*idx
  localparam logic [11:0] IDX_INDIRECT_PLAIN_PORT_1    = 12'hfe7; // plain port, pointer 1
  localparam logic [11:0] IDX_WORKING_REGISTER     = 12'hfe8; // working register
  localparam logic [11:0] IDX_INDIRECT_POINTER0_LOW    = 12'hfe9; // pointer 0 low byte
  localparam logic [11:0] IDX_INDIRECT_POINTER0_HIGH    = 12'hfea; // pointer 0 high nibble
  localparam logic [11:0] IDX_PLUSW    = 12'hfeb; // offset port
  localparam logic [11:0] IDX_PREINC   = 12'hfec; // pre-increment port
  localparam logic [11:0] IDX_POSTDEC  = 12'hfed; // post-decrement port
  localparam logic [11:0] IDX_POSTINC  = 12'hfee; // post-increment port
  localparam logic [11:0] IDX_INDIRECT_PLAIN_PORT_0    = 12'hfef; // plain port, pointer 0
  localparam logic [11:0] IDX_ICTL3    = 12'hff0;
  localparam logic [11:0] IDX_ICTL2    = 12'hff1;
  localparam logic [11:0] IDX_ICTL1    = 12'hff2;
  localparam logic [11:0] IDX_PRODUCT_LOW    = 12'hff3;
  localparam logic [11:0] IDX_PRODUCT_HIGH    = 12'hff4;
  localparam logic [11:0] IDX_TABLE_LATCH   = 12'hff5;
  localparam logic [11:0] IDX_TBLL     = 12'hff6;
  localparam logic [11:0] IDX_TBLH     = 12'hff7;
  localparam logic [11:0] IDX_TBLU     = 12'hff8;
  localparam logic [11:0] IDX_PCL      = 12'hff9;
  localparam logic [11:0] IDX_PROGRAM_COUNTER_HOLD_HIGH   = 12'hffa;
  localparam logic [11:0] IDX_PROGRAM_COUNTER_HOLD_UPPER   = 12'hffb;
  localparam logic [11:0] IDX_STACK_POINTER_STATUS   = 12'hffc;
  localparam logic [11:0] IDX_STACK_TOP_LOW     = 12'hffd;
  localparam logic [11:0] IDX_STACK_TOP_HIGH     = 12'hffe;
  localparam logic [11:0] IDX_STACK_TOP_UPPER     = 12'hfff;
  // context-defined shared slots and their mode controls
  localparam logic [11:0] IDX_SERSHARE = 12'hfc8; // slave address / mask
  localparam logic [11:0] IDX_PARADRH  = 12'hf6f; // parallel pair high
  localparam logic [11:0] IDX_PARADRL  = 12'hf6e; // parallel pair low
  localparam logic [11:0] IDX_PAROUTH  = 12'hf5b; // same pair, second name
  localparam logic [11:0] IDX_PAROUTL  = 12'hf5a;
  localparam logic [11:0] IDX_MODECTL  = 12'hf00; // mode control byte
  localparam int          MODE_MASKSEL = 0;       // serial mask selected
  localparam int          MODE_PARMST  = 1;       // parallel port is master
  // reset values
  localparam logic [7:0]  RST_ZERO     = 8'h00;
  localparam logic [7:0]  RST_ICTL3    = 8'hc0;
  localparam logic [7:0]  RST_ICTL2    = 8'hff;
  localparam logic [7:0]  RST_FF       = 8'hff;
  // implemented widths of partial bytes
  localparam logic [7:0]  MSK_HI4      = 8'h0f; // pointer 0 high
  localparam logic [7:0]  MSK_U5       = 8'h1f; // program_counter_hold_upper, stack_top_upper
  localparam logic [7:0]  MSK_TBLU     = 8'h3f; // table pointer upper
  localparam logic [7:0]  MSK_STK      = 8'hdf; // stkful, stkunf, sp<4:0>
  // data memory size in bytes (12-bit address)
  localparam int          DMEM_DEPTH   = 4096;
  // ahb encodings
  localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;
endpackage : core_sfr_pkg

// file: verif/core_bus_master.sv
// processor-core side model: single-word ahb-lite master for sfr accesses
`timescale 1ns/1ps

module core_bus_master (
  input  wire logic        clk_sys, // core clock
  input  wire logic        hready,  // bus ready, the slave's hreadyout
  input  wire logic [31:0] hrdata,  // read data from the bank
  output logic             hsel,    // slave select
  output logic      [31:0] haddr,   // byte address, four times the index
  output logic      [1:0]  htrans,  // idle or nonseq
  output logic             hwrite,  // high for a write
  output logic      [2:0]  hsize,   // always a whole word
  output logic      [31:0] hwdata   // write data, low byte used
);
  //////////////////////////////////////////////////////////////////////////
  // idle bus from time zero
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h5a5a5a5a;
  end

  //////////////////////////////////////////////////////////////////////////
  // one transfer: called just after a rising edge, returns just after one
  task automatic access(input logic wr, input logic [11:0] idx,
                        input logic [7:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {18'h00000, idx, 2'h0};
    htrans <= core_sfr_pkg::HTRANS_NSEQ;
    hwrite <= wr;
    // hold the address phase until the slave takes it
    do @(posedge clk_sys); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= {24'h000000, wd};
    // hold the data phase; read data is taken at the closing edge
    do @(posedge clk_sys); while (hready !== 1'b1);
    rd = hrdata;
    // released data line shows the inverse, never the stale value
    hwdata <= ~{24'h000000, wd};
    // one idle cycle so a dependent read never sees the old value
    @(posedge clk_sys);
  endtask
endmodule // core_bus_master

// file: verif/test_core_sfr_map_indirect_access.sv
// self-checking testbench for the core sfr bank and its indirect ports
`timescale 1ns/1ps

module test_core_sfr_map_indirect_access;
  logic        clk_sys;     // 10 mhz core clock
  logic        rst;         // synchronous reset
  logic        hsel;        // bus signals from the core model
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;      // bank outputs
  logic        hreadyout;
  logic        hresp;
  logic [11:0] indirect_pointer_zero;
  logic [20:0] tablePtr;
  logic        serMaskSel;
  logic        parMaster;
  logic [31:0] rdat;        // last read word
  int          n_errors;    // mismatches
  int          comparisons; // checks made

  //////////////////////////////////////////////////////////////////////////
  // clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  //////////////////////////////////////////////////////////////////////////
  // design and core model; hready is the one slave's hreadyout
  core_sfr_bank u_dut (
    .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .indirect_pointer_zero(indirect_pointer_zero), .tablePtr(tablePtr),
    .serMaskSel(serMaskSel), .parMaster(parMaster));

  core_bus_master u_core (
    .clk_sys(clk_sys), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata));

  //////////////////////////////////////////////////////////////////////////
  // compare, write and read helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    u_core.access(1'b1, idx, d, rdat);
  endtask

  task automatic rd(input logic [11:0] idx, input logic [7:0] e);
    u_core.access(1'b0, idx, 8'h00, rdat);
    chk(rdat, {24'h000000, e});
    chk({31'h0, hresp}, 32'h0); // the bank only ever answers okay
  endtask

  task automatic report_and_stop();
    $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  // watchdog: the whole sequence needs well under 500 cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_errors++;
    $display("watchdog expired");
    report_and_stop();
  end

  //////////////////////////////////////////////////////////////////////////
  // test sequence
  initial begin
    n_errors    = 0;
    comparisons = 0;
    rst         = 1'b1;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    // reset values after release
    rd(core_sfr_pkg::IDX_ICTL3, 8'hc0);
    rd(core_sfr_pkg::IDX_ICTL2, 8'hff);
    rd(core_sfr_pkg::IDX_TBLU, 8'h00);
    rd(core_sfr_pkg::IDX_PCL, 8'h00);
    rd(core_sfr_pkg::IDX_PROGRAM_COUNTER_HOLD_HIGH, 8'h00);
    rd(core_sfr_pkg::IDX_PROGRAM_COUNTER_HOLD_UPPER, 8'h00);
    rd(core_sfr_pkg::IDX_STACK_POINTER_STATUS, 8'h00);
    rd(core_sfr_pkg::IDX_STACK_TOP_LOW, 8'h00);
    rd(core_sfr_pkg::IDX_STACK_TOP_HIGH, 8'h00);
    rd(core_sfr_pkg::IDX_STACK_TOP_UPPER, 8'h00);
    rd(core_sfr_pkg::IDX_INDIRECT_POINTER0_HIGH, 8'h00);
    chk({20'h0, indirect_pointer_zero}, 32'h0);
    $display("test reset_values done");
    // table pointer bytes land on their own bit slices
    wr(core_sfr_pkg::IDX_TBLL, 8'h34);
    wr(core_sfr_pkg::IDX_TBLH, 8'h12);
    wr(core_sfr_pkg::IDX_TBLU, 8'h05);
    chk({11'h0, tablePtr}, 32'h00051234);
    rd(core_sfr_pkg::IDX_TBLH, 8'h12);
    $display("test table_pointer done");
    // indirect ports through pointer 0
    wr(core_sfr_pkg::IDX_INDIRECT_POINTER0_HIGH, 8'h01);
    wr(core_sfr_pkg::IDX_INDIRECT_POINTER0_LOW, 8'h10);
    chk({20'h0, indirect_pointer_zero}, 32'h110);
    wr(core_sfr_pkg::IDX_INDIRECT_PLAIN_PORT_0, 8'ha5);
    chk({20'h0, indirect_pointer_zero}, 32'h110);
    wr(core_sfr_pkg::IDX_POSTINC, 8'h11);
    chk({20'h0, indirect_pointer_zero}, 32'h111);
    wr(core_sfr_pkg::IDX_INDIRECT_PLAIN_PORT_0, 8'h22);
    rd(core_sfr_pkg::IDX_POSTDEC, 8'h22);
    chk({20'h0, indirect_pointer_zero}, 32'h110);
    rd(core_sfr_pkg::IDX_INDIRECT_PLAIN_PORT_0, 8'h11);
    rd(core_sfr_pkg::IDX_PREINC, 8'h22);
    chk({20'h0, indirect_pointer_zero}, 32'h111);
    // a working register of ff is an offset of minus one
    wr(core_sfr_pkg::IDX_WORKING_REGISTER, 8'hff);
    rd(core_sfr_pkg::IDX_PLUSW, 8'h11);
    chk({20'h0, indirect_pointer_zero}, 32'h111);
    wr(core_sfr_pkg::IDX_WORKING_REGISTER, 8'h02);
    wr(core_sfr_pkg::IDX_PLUSW, 8'h77);
    wr(core_sfr_pkg::IDX_INDIRECT_POINTER0_LOW, 8'h13);
    rd(core_sfr_pkg::IDX_INDIRECT_PLAIN_PORT_0, 8'h77);
    $display("test indirect_ports done");
    // shared serial slot: address or mask by mode
    wr(core_sfr_pkg::IDX_MODECTL, 8'h00);
    wr(core_sfr_pkg::IDX_SERSHARE, 8'h3c);
    wr(core_sfr_pkg::IDX_MODECTL, 8'h01);
    chk({31'h0, serMaskSel}, 32'h1);
    rd(core_sfr_pkg::IDX_SERSHARE, 8'hff);
    wr(core_sfr_pkg::IDX_SERSHARE, 8'h0f);
    wr(core_sfr_pkg::IDX_MODECTL, 8'h00);
    rd(core_sfr_pkg::IDX_SERSHARE, 8'h3c);
    wr(core_sfr_pkg::IDX_MODECTL, 8'h01);
    rd(core_sfr_pkg::IDX_SERSHARE, 8'h0f);
    $display("test serial_shared done");
    // parallel pair: one store under two names in either mode
    wr(core_sfr_pkg::IDX_MODECTL, 8'h02);
    chk({31'h0, parMaster}, 32'h1);
    wr(core_sfr_pkg::IDX_PARADRH, 8'hab);
    rd(core_sfr_pkg::IDX_PAROUTH, 8'hab);
    wr(core_sfr_pkg::IDX_MODECTL, 8'h00);
    chk({31'h0, parMaster}, 32'h0);
    wr(core_sfr_pkg::IDX_PAROUTL, 8'hcd);
    rd(core_sfr_pkg::IDX_PARADRL, 8'hcd);
    $display("test parallel_pair done");
    // unmapped places read zero and ignore writes
    rd(core_sfr_pkg::IDX_INDIRECT_PLAIN_PORT_1, 8'h00);
    wr(12'h001, 8'h5a);
    rd(12'h001, 8'h00);
    $display("test unmapped done");
    report_and_stop();
  end
endmodule // test_core_sfr_map_indirect_access
